// >>> rtl/tmc_timer.sv
// Sixteen bit timer counter with APB registers, prescaler and special event reset.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns

module tmc_timer #(
  parameter int INSTR_DIV = tmc_pkg::TMC_INSTR_DIV
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External clock and crystal pins.
  input wire logic ext_clk_pin,
  input wire logic crystal_input_pin,
  output logic crystal_amp_output_pin,
  output logic osc_running,
  // Power state.
  input wire logic sleep_mode,
  // Capture compare unit and converter.
  input wire logic [3:0] compare_mode_field,
  input wire logic [15:0] compare_value_pair,
  input wire logic adc_enabled,
  output logic adc_start,
  // Interrupt request.
  output logic overflow_irq,
  output logic overflow_irq_high
);
  import tmc_pkg::*;

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [7:0] hi_buf_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] flags_reg;
  logic [7:0] enables_reg;
  logic [7:0] prio_reg;
  logic [2:0] psc_reg;
  logic [2:0] psc_limit;
  logic [7:0] div_reg;
  logic instr_tick;
  logic [2:0] ext_sync_reg;
  logic [2:0] xtal_sync_reg;
  logic ext_level_reg;
  logic xtal_level_reg;
  logic ext_rise;
  logic xtal_rise;
  logic src_tick;
  logic cnt_tick;
  logic match_hold_reg;
  logic trigger;
  logic overflow;
  logic wr_done;
  logic rd_setup;
  logic wr_lo;
  logic wr_hi;
  logic rd_lo;
  logic mapped;
  logic [31:0] rd_value;

  logic ctl_on;
  logic ctl_cs;
  logic ctl_osc;
  logic ctl_wide;
  logic [1:0] ctl_ps;

  // The sync select bit is stored but has no effect: external inputs are
  // always synchronised, so the trigger reset works in every counter mode.
  assign ctl_on = ctrl_reg[TMC_CTRL_ON];
  assign ctl_cs = ctrl_reg[TMC_CTRL_CS];
  assign ctl_osc = ctrl_reg[TMC_CTRL_OSC];
  assign ctl_wide = ctrl_reg[TMC_CTRL_WIDE];
  assign ctl_ps = ctrl_reg[TMC_CTRL_PS_LO +: 2];

  // Bus phases: writes act at the completing access edge, read data is
  // prepared at the setup edge so it is ready in the access cycle.
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_lo = wr_done && (paddr == TMC_OFS_CNT_LO);
  assign wr_hi = wr_done && (paddr == TMC_OFS_CNT_HI);
  assign rd_lo = rd_setup && (paddr == TMC_OFS_CNT_LO);

  // Address decode for reads and error reporting.
  always_comb begin
    mapped = 1'b1;
    rd_value = 32'h0000_0000;
    if (paddr == TMC_OFS_CNT_LO) begin
      rd_value[7:0] = cnt_reg[7:0];
    end else if (paddr == TMC_OFS_CNT_HI) begin
      rd_value[7:0] = ctl_wide ? hi_buf_reg : cnt_reg[15:8];
    end else if (paddr == TMC_OFS_CTRL) begin
      rd_value[7:0] = ctrl_reg;
    end else if (paddr == TMC_OFS_FLAGS) begin
      rd_value[7:0] = flags_reg;
    end else if (paddr == TMC_OFS_ENABLES) begin
      rd_value[7:0] = enables_reg;
    end else if (paddr == TMC_OFS_PRIO) begin
      rd_value[7:0] = prio_reg;
    end else begin
      mapped = 1'b0;
    end
  end

  // Ready is raised for the access cycle that follows each setup cycle.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_value;
    end
  end

  // Control register; reset leaves the counter stopped on the internal
  // clock with a 1:1 prescale.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= TMC_CTRL_RESET;
    end else if (wr_done && paddr == TMC_OFS_CTRL) begin
      ctrl_reg <= pwdata[7:0] & TMC_CTRL_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      enables_reg <= TMC_IRQ_RESET;
      prio_reg <= TMC_IRQ_RESET;
    end else begin
      if (wr_done && paddr == TMC_OFS_ENABLES) begin
        enables_reg <= pwdata[7:0] & TMC_IRQ_MASK;
      end
      if (wr_done && paddr == TMC_OFS_PRIO) begin
        prio_reg <= pwdata[7:0] & TMC_IRQ_MASK;
      end
    end
  end

  // Sticky overflow flag; a wrap in the clearing cycle still sets it.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= TMC_IRQ_RESET;
    end else if (overflow) begin
      flags_reg[TMC_OVF_BIT] <= 1'b1;
    end else if (wr_done && paddr == TMC_OFS_FLAGS) begin
      flags_reg <= pwdata[7:0] & TMC_IRQ_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_irq <= 1'b0;
      overflow_irq_high <= 1'b0;
    end else begin
      overflow_irq <= flags_reg[TMC_OVF_BIT] && enables_reg[TMC_OVF_BIT];
      overflow_irq_high <= flags_reg[TMC_OVF_BIT] && enables_reg[TMC_OVF_BIT]
                           && prio_reg[TMC_OVF_BIT];
    end
  end

  // Crystal oscillator control; sleep has no say over it.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_running <= 1'b0;
      crystal_amp_output_pin <= 1'b0;
    end else begin
      osc_running <= ctl_osc;
      crystal_amp_output_pin <= ctl_osc && !xtal_sync_reg[2];
    end
  end

  // Pin synchronisers; a level is accepted once the last two stages agree.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_sync_reg <= 3'h0;
      xtal_sync_reg <= 3'h0;
      ext_level_reg <= 1'b0;
      xtal_level_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_pin};
      xtal_sync_reg <= {xtal_sync_reg[1:0], crystal_input_pin};
      if (ext_sync_reg[1] == ext_sync_reg[2]) begin
        ext_level_reg <= ext_sync_reg[2];
      end
      if (xtal_sync_reg[1] == xtal_sync_reg[2]) begin
        xtal_level_reg <= xtal_sync_reg[2];
      end
    end
  end

  assign ext_rise = ext_sync_reg[1] && ext_sync_reg[2] && !ext_level_reg;
  assign xtal_rise = xtal_sync_reg[1] && xtal_sync_reg[2] && !xtal_level_reg;

  // Instruction cycle divider; the core clock is held in sleep.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 8'h00;
    end else if (sleep_mode) begin
      div_reg <= div_reg;
    end else if (div_reg == 8'(INSTR_DIV - 1)) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  assign instr_tick = !sleep_mode && (div_reg == 8'(INSTR_DIV - 1));

  // Source selection between the instruction clock and the external edges.
  always_comb begin
    if (!ctl_cs) begin
      src_tick = instr_tick;
    end else if (ctl_osc) begin
      src_tick = xtal_rise;
    end else begin
      src_tick = ext_rise;
    end
  end

  // Prescaler divides the source by 1, 2, 4 or 8.
  always_comb begin
    case (ctl_ps)
      2'b00: psc_limit = 3'h0;
      2'b01: psc_limit = 3'h1;
      2'b10: psc_limit = 3'h3;
      default: psc_limit = 3'h7;
    endcase
  end

  // Only a low byte write clears the prescaler; control and high byte
  // writes leave its phase alone.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      psc_reg <= 3'h0;
    end else if (wr_lo) begin
      psc_reg <= 3'h0;
    end else if (ctl_on && src_tick) begin
      psc_reg <= (psc_reg >= psc_limit) ? 3'h0 : psc_reg + 3'h1;
    end
  end

  assign cnt_tick = ctl_on && src_tick && (psc_reg >= psc_limit);

  // The compare value is the period: a match in trigger mode fires once
  // per match and restarts counting from zero.
  assign trigger = (compare_mode_field == TMC_MODE_SPECIAL)
                   && (cnt_reg == compare_value_pair) && !match_hold_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      match_hold_reg <= 1'b0;
    end else begin
      match_hold_reg <= (cnt_reg == compare_value_pair);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= trigger && adc_enabled;
    end
  end

  // Overflow only comes from a counting wrap, never from a write or trigger.
  assign overflow = cnt_tick && !trigger && !wr_lo && !wr_hi
                    && (cnt_reg == TMC_CNT_MAX);

  // Counter priority: bus write, then trigger reset, then count.
  always_comb begin
    cnt_next = cnt_reg;
    if (wr_lo) begin
      cnt_next[7:0] = pwdata[7:0];
      if (ctl_wide) begin
        cnt_next[15:8] = hi_buf_reg;
      end
    end else if (wr_hi) begin
      if (!ctl_wide) begin
        cnt_next[15:8] = pwdata[7:0];
      end
    end else if (trigger) begin
      cnt_next = TMC_CNT_ZERO;
    end else if (cnt_tick) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  // Write beats a coincident trigger because the write branch comes first.
  // The counter has no reset so that it keeps its value across resets.
  always_ff @(posedge sys_clk) begin
    cnt_reg <= cnt_next;
  end

  // High byte buffer for coherent wide access.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_buf_reg <= 8'h00;
    end else if (ctl_wide && rd_lo) begin
      hi_buf_reg <= cnt_reg[15:8];
    end else if (ctl_wide && wr_hi) begin
      hi_buf_reg <= pwdata[7:0];
    end
  end

endmodule : tmc_timer

// >>> rtl/tmc_pkg.sv
// Shared constants for the sixteen bit timer counter.
package tmc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] TMC_OFS_CNT_LO = 8'h00;
  localparam logic [7:0] TMC_OFS_CNT_HI = 8'h04;
  localparam logic [7:0] TMC_OFS_CTRL = 8'h08;
  localparam logic [7:0] TMC_OFS_FLAGS = 8'h0c;
  localparam logic [7:0] TMC_OFS_ENABLES = 8'h10;
  localparam logic [7:0] TMC_OFS_PRIO = 8'h14;

  // Field positions in counter_control.
  localparam int TMC_CTRL_ON = 0;
  localparam int TMC_CTRL_CS = 1;
  localparam int TMC_CTRL_SYNC = 2;
  localparam int TMC_CTRL_OSC = 3;
  localparam int TMC_CTRL_PS_LO = 4;
  localparam int TMC_CTRL_WIDE = 7;
  localparam logic [7:0] TMC_CTRL_MASK = 8'hbf;
  localparam logic [7:0] TMC_CTRL_RESET = 8'h00;

  // Overflow bit position in the flag, enable and priority registers.
  localparam int TMC_OVF_BIT = 0;
  localparam logic [7:0] TMC_IRQ_MASK = 8'h01;
  localparam logic [7:0] TMC_IRQ_RESET = 8'h00;

  // Compare mode code that selects the special event trigger.
  localparam logic [3:0] TMC_MODE_SPECIAL = 4'hb;

  // Counter limits.
  localparam logic [15:0] TMC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TMC_CNT_MAX = 16'hffff;

  // Core clock cycles per instruction cycle.
  localparam int TMC_INSTR_DIV = 4;

endpackage : tmc_pkg

// >>> tb/tmc_ccp_model.sv
// Far side model: compare unit, converter enable and external count source.
`timescale 1ns/1ns
module tmc_ccp_model import tmc_pkg::*; (
  // Clock, reset and bench controls.
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic trig_on,
  input wire logic ext_run,
  input wire logic [15:0] period,
  // Timer side.
  input wire logic adc_start,
  output logic [3:0] compare_mode_field,
  output logic [15:0] compare_value_pair,
  output logic adc_enabled,
  output logic ext_clk_pin,
  output logic crystal_input_pin,
  output int adc_cnt,
  output int edge_cnt
);
  logic [2:0] div_reg;
  assign compare_mode_field = trig_on ? TMC_MODE_SPECIAL : 4'h0;
  assign compare_value_pair = period;
  assign adc_enabled = trig_on;
  assign crystal_input_pin = ext_clk_pin;
  // The pin parks low, so a stopped source never leaves half an edge behind.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 3'h0;
      ext_clk_pin <= 1'b0;
      edge_cnt <= 0;
      adc_cnt <= 0;
    end else begin
      div_reg <= div_reg + 3'h1;
      if (div_reg == 3'h7 && (ext_run || ext_clk_pin)) begin
        ext_clk_pin <= ~ext_clk_pin;
        edge_cnt <= edge_cnt + int'(!ext_clk_pin);
      end
      if (adc_start) adc_cnt <= adc_cnt + 1;
    end
  end
endmodule : tmc_ccp_model

// >>> tb/tmc_timer_asserts.sv
// Port checker for the timer counter.
`timescale 1ns/1ns
module tmc_timer_asserts import tmc_pkg::*; #(
  parameter int INSTR_DIV = TMC_INSTR_DIV
) (
  // Clock, reset and bus.
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer outputs and compare side.
  input wire logic [3:0] compare_mode_field,
  input wire logic adc_enabled,
  input wire logic adc_start,
  input wire logic overflow_irq,
  input wire logic osc_running,
  input wire logic crystal_amp_output_pin
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence setup_s; psel && !penable; endsequence
  sequence wr_s; psel && penable && pwrite; endsequence
  apb_ready_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  err_map_a: assert property (pslverr |-> psel && (paddr > TMC_OFS_PRIO || paddr[1:0] != 2'h0))
    else $error("error on a mapped address");
  irq_gate_a: assert property (wr_s and paddr == TMC_OFS_ENABLES && !pwdata[0]
    |-> ##2 !overflow_irq) else $error("request while disabled");
  adc_cause_a: assert property (adc_start |-> $past(adc_enabled)
    && $past(compare_mode_field) == TMC_MODE_SPECIAL) else $error("stray conversion start");
  adc_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("conversion start too long");
  osc_follow_a: assert property (wr_s and paddr == TMC_OFS_CTRL
    |-> ##2 osc_running == $past(pwdata[TMC_CTRL_OSC], 2)) else $error("oscillator state wrong");
  amp_gate_a: assert property (crystal_amp_output_pin |-> osc_running)
    else $error("amplifier driven while off");
  reset_idle_a: assert property ($rose(rst_b) |-> !adc_start && !overflow_irq && !osc_running)
    else $error("outputs busy after reset");
endmodule : tmc_timer_asserts

bind tmc_timer tmc_timer_asserts #(.INSTR_DIV(INSTR_DIV)) u_chk (.sys_clk(sys_clk),
  .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .adc_start(adc_start),
  .compare_mode_field(compare_mode_field), .adc_enabled(adc_enabled),
  .overflow_irq(overflow_irq), .osc_running(osc_running),
  .crystal_amp_output_pin(crystal_amp_output_pin));

// >>> tb/tmc_timer_test.sv
// Self-checking testbench for the timer counter.
`timescale 1ns/1ns
module tmc_timer_test;
  import tmc_pkg::*;
  localparam logic [7:0] LO = TMC_OFS_CNT_LO;
  localparam logic [7:0] HI = TMC_OFS_CNT_HI;
  localparam logic [7:0] CT = TMC_OFS_CTRL;
  localparam logic [7:0] FL = TMC_OFS_FLAGS;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, ext_clk_pin, crystal_input_pin;
  logic amp, osc_running, sleep_mode, adc_enabled, adc_start, irq, irq_hi, trig_on, ext_run;
  logic [7:0] paddr, r;
  logic [31:0] pwdata, prdata;
  logic err;
  logic [3:0] mode;
  logic [15:0] cmp, period, v;
  int error_cnt, compares, adc_cnt, edge_cnt, e;
  tmc_timer uut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .crystal_input_pin(crystal_input_pin),
    .crystal_amp_output_pin(amp), .osc_running(osc_running), .sleep_mode(sleep_mode),
    .compare_mode_field(mode), .compare_value_pair(cmp), .adc_enabled(adc_enabled),
    .adc_start(adc_start), .overflow_irq(irq), .overflow_irq_high(irq_hi));
  tmc_ccp_model far (.sys_clk(sys_clk), .rst_b(rst_b), .trig_on(trig_on), .ext_run(ext_run),
    .period(period), .adc_start(adc_start), .compare_mode_field(mode),
    .compare_value_pair(cmp), .adc_enabled(adc_enabled), .ext_clk_pin(ext_clk_pin),
    .crystal_input_pin(crystal_input_pin), .adc_cnt(adc_cnt), .edge_cnt(edge_cnt));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task apb(input logic w, input logic [7:0] a, d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function logic [7:0] near(int got, int ex);
    return {7'h0, got >= ex - 1 && got <= ex + 1};
  endfunction : near
  task done(input string s);
    $display("test %s finished", s);
  endtask : done
  task print_verdict;
    $display("%0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task clr;
    apb(1, LO, 0);
    apb(1, HI, 0);
  endtask : clr
  initial begin
    {psel, penable, pwrite, paddr, pwdata, trig_on, ext_run, sleep_mode, period} = '0;
    rst_b = 1'b0;
    error_cnt = 0;
    compares = 0;
    void'($urandom(32'he863));
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 8; a <= 24; a += 4) begin
      apb(0, 8'(a), 0);
      chk(r, 8'h00);
      chk({7'h0, err}, {7'h0, a > 20});
    end
    done("reset");
    v = 16'($urandom);
    apb(1, LO, v[7:0]);
    apb(1, HI, v[15:8]);
    repeat (30) @(posedge sys_clk);
    apb(0, LO, 0);
    chk(r, v[7:0]);
    apb(0, HI, 0);
    chk(r, v[15:8]);
    for (int ps = 0; ps < 4; ps++) begin
      clr();
      apb(1, CT, 8'h01 | 8'(ps << 4));
      repeat (256) @(posedge sys_clk);
      apb(1, CT, 0);
      apb(0, LO, 0);
      chk(near(r, 259 / (TMC_INSTR_DIV << ps)), 8'h01);
    end
    done("prescale");
    apb(1, TMC_OFS_ENABLES, 1);
    apb(1, TMC_OFS_PRIO, 1);
    apb(1, HI, 8'hff);
    apb(1, LO, 8'hfe);
    apb(1, CT, 1);
    repeat (40) @(posedge sys_clk);
    chk({6'h0, irq, irq_hi}, 8'h03);
    apb(1, TMC_OFS_ENABLES, 0);
    apb(1, CT, 0);
    chk({7'h0, irq}, 8'h00);
    apb(0, HI, 0);
    chk(r, 8'h00);
    apb(0, FL, 0);
    chk(r, 8'h01);
    apb(1, FL, 0);
    apb(0, FL, 0);
    chk(r, 8'h00);
    done("overflow");
    apb(1, CT, 8'h80);
    apb(1, HI, 8'ha5);
    apb(1, LO, 8'h3c);
    apb(1, HI, 8'h11);
    apb(1, CT, 0);
    apb(0, HI, 0);
    chk(r, 8'ha5);
    apb(1, HI, 8'h77);
    apb(1, CT, 8'h80);
    apb(0, HI, 0);
    chk(r, 8'h11);
    apb(0, LO, 0);
    chk(r, 8'h3c);
    apb(0, HI, 0);
    chk(r, 8'h77);
    done("wide");
    period <= 16'($urandom_range(24, 8));
    apb(1, CT, 0);
    clr();
    trig_on <= 1'b1;
    apb(1, CT, 1);
    repeat (400) @(posedge sys_clk);
    apb(1, CT, 0);
    trig_on <= 1'b0;
    chk(near(adc_cnt, 403 / (TMC_INSTR_DIV * period)), 8'h01);
    apb(0, FL, 0);
    chk(r, 8'h00);
    apb(0, LO, 0);
    chk({7'h0, r <= period[7:0]}, 8'h01);
    period <= TMC_CNT_MAX;
    trig_on <= 1'b1;
    apb(1, HI, 8'hff);
    apb(1, LO, 8'hf8);
    apb(1, CT, 1);
    repeat (60) @(posedge sys_clk);
    apb(1, CT, 0);
    trig_on <= 1'b0;
    apb(0, FL, 0);
    chk(r, 8'h00);
    apb(0, HI, 0);
    chk(r, 8'h00);
    done("trigger");
    for (int k = 0; k < 2; k++) begin
      clr();
      apb(1, CT, k ? 8'h0b : 8'h03);
      repeat (20) @(posedge sys_clk);
      e = edge_cnt;
      ext_run <= 1'b1;
      repeat (200) @(posedge sys_clk);
      ext_run <= 1'b0;
      repeat (20) @(posedge sys_clk);
      apb(0, LO, 0);
      chk(r, 8'(edge_cnt - e));
    end
    done("external");
    clr();
    sleep_mode <= 1'b1;
    apb(1, CT, 8'h09);
    repeat (40) @(posedge sys_clk);
    chk({7'h0, osc_running}, 8'h01);
    apb(1, CT, 8'h08);
    apb(0, LO, 0);
    chk(r, 8'h00);
    sleep_mode <= 1'b0;
    done("sleep");
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    print_verdict();
  end
endmodule : tmc_timer_test
